// >>> core/oeim_params.svh
`ifndef OEIM_PARAMS_SVH
`define OEIM_PARAMS_SVH
`define OEIM_PAT_W 32
`define OEIM_IDX_W 5
`define OEIM_TASK_W 8
`define OEIM_EDGE_W 64
`define OEIM_PAT_RST 32'h0000_0000
`define OEIM_PEND_RST 64'h0000_0000_0000_0000
`define OEIM_TASK_RST 8'h00
`endif

// >>> core/oeim_pkg.sv
`include "oeim_params.svh"
package oeim_pkg;
   typedef logic [`OEIM_PAT_W-1:0] oeim_pat_t;
   typedef logic [`OEIM_EDGE_W-1:0] oeim_edge_t;
   typedef logic [`OEIM_TASK_W-1:0] oeim_task_t;
   typedef enum logic [0:0] {
      OEIM_IDLE = 1'b0,
      OEIM_BUSY = 1'b1
   } oeim_state_t;
endpackage : oeim_pkg

// >>> core/oeim_pick.sv
`timescale 1ns/1ns
`include "oeim_params.svh"
// Lowest-index pending edge finder; a small priority encoder kept apart.
module oeim_pick (
   input wire logic [`OEIM_EDGE_W-1:0] pend_in,
   output logic found_out,
   output logic [5:0] slot_out
);
   // Scan from the top so the lowest slot wins, giving bit 0 rising first.
   always_comb begin
      found_out = 1'b0;
      slot_out = 6'h00;
      for (int i = `OEIM_EDGE_W - 1; i >= 0; i--) begin
         if (pend_in[i]) begin
            found_out = 1'b1;
            slot_out = 6'(i);
         end
      end
   end
endmodule : oeim_pick

// >>> core/oeim_mapper.sv
`timescale 1ns/1ns
`include "oeim_params.svh"
// Turns pattern edges into external interrupt task requests, one at a time.
module oeim_mapper (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic [`OEIM_PAT_W-1:0] pattern_in,
   input wire logic [`OEIM_PAT_W-1:0] irq_enable_in,
   input wire logic [`OEIM_TASK_W-1:0] task_base_in,
   input wire logic req_ack_in,
   output logic req_valid_out,
   output logic [`OEIM_TASK_W-1:0] req_task_out,
   output logic overrun_out
);
   oeim_pkg::oeim_pat_t prev_reg;
   oeim_pkg::oeim_edge_t pend_reg;
   oeim_pkg::oeim_edge_t pend_next;
   oeim_pkg::oeim_edge_t new_edges;
   oeim_pkg::oeim_edge_t clr_mask;
   oeim_pkg::oeim_state_t state_reg;
   oeim_pkg::oeim_task_t task_reg;
   logic valid_reg;
   logic overrun_reg;
   logic found;
   logic [5:0] slot;
   wire [`OEIM_PAT_W-1:0] rise_w;
   wire [`OEIM_PAT_W-1:0] fall_w;
   wire take_w;
   wire done_w;

   // Task slot for bit k and edge kind: slot 2k rising, 2k+1 falling.
   function automatic logic [5:0] slot_of(input logic [4:0] k, input logic falling);
      slot_of = {k, falling};
   endfunction : slot_of

   // Task number for a slot; the sum wraps at eight bits, so a high base folds back to zero.
   function automatic logic [7:0] task_of(input logic [7:0] base, input logic [5:0] s);
      task_of = base + {2'b00, s};
   endfunction : task_of

   // Edges come from the unit pattern itself, so pinless bits count too.
   assign rise_w = pattern_in & ~prev_reg & irq_enable_in;
   assign fall_w = ~pattern_in & prev_reg & irq_enable_in;

   // Interleave into 64 slots, one pair per output bit.
   always_comb begin
      new_edges = `OEIM_PEND_RST;
      for (int k = 0; k < `OEIM_PAT_W; k++) begin
         new_edges[slot_of(5'(k), 1'b0)] = rise_w[k];
         new_edges[slot_of(5'(k), 1'b1)] = fall_w[k];
      end
   end

   oeim_pick u_pick (
      .pend_in(pend_reg),
      .found_out(found),
      .slot_out(slot)
   );

   // A new slot is loaded, and leaves the queue, only when idle; the request is retired on ack.
   assign take_w = (state_reg == oeim_pkg::OEIM_IDLE) && found;
   assign done_w = (state_reg == oeim_pkg::OEIM_BUSY) && req_ack_in;
   always_comb begin
      clr_mask = `OEIM_PEND_RST;
      if (take_w) begin
         clr_mask[slot] = 1'b1;
      end
   end
   // A fresh edge in the same cycle as its slot is taken stays queued.
   assign pend_next = (pend_reg & ~clr_mask) | new_edges;

   // Pattern history and queue of pending edges.
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         prev_reg <= `OEIM_PAT_RST;
         pend_reg <= `OEIM_PEND_RST;
         overrun_reg <= 1'b0;
      end else begin
         prev_reg <= pattern_in;
         pend_reg <= pend_next;
         overrun_reg <= |(pend_reg & ~clr_mask & new_edges);
      end
   end

   // Request handshake: the task holds until the CPU side acknowledges.
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         state_reg <= oeim_pkg::OEIM_IDLE;
         task_reg <= `OEIM_TASK_RST;
         valid_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            oeim_pkg::OEIM_IDLE: begin
               if (found) begin
                  task_reg <= task_of(task_base_in, slot);
                  valid_reg <= 1'b1;
                  state_reg <= oeim_pkg::OEIM_BUSY;
               end
            end
            oeim_pkg::OEIM_BUSY: begin
               if (done_w) begin
                  valid_reg <= 1'b0;
                  state_reg <= oeim_pkg::OEIM_IDLE;
               end
            end
         endcase
      end
   end

   assign req_valid_out = valid_reg;
   assign req_task_out = task_reg;
   assign overrun_out = overrun_reg;

   // Checks on the edge queue and the request side.
   // A rising slot keeps the parity of the base, since its slot number is even.
   rise_task_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_reg == oeim_pkg::OEIM_IDLE && found && !slot[0])
      |=> req_valid_out && (!task_reg[0] == !($past(task_base_in[0]))))
      else $error("rising task number wrong");

   // Every loaded request carries the base plus its slot.
   fall_task_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (take_w)
      |=> req_task_out == $past(task_base_in) + {2'b00, $past(slot)})
      else $error("task number not base plus slot");

   // With nothing enabled no edge may reach the queue.
   enable_gate_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (irq_enable_in == 32'h0000_0000)
      |-> (new_edges == `OEIM_PEND_RST))
      else $error("disabled output made an edge");

   // A rising edge on bit 0 lands in slot 0.
   rise_slot_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (irq_enable_in[0] && pattern_in[0] && !prev_reg[0])
      |=> pend_reg[0])
      else $error("bit 0 rise not queued");

   // The last bit's falling edge uses the last slot.
   top_fall_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (irq_enable_in[31] && !pattern_in[31] && prev_reg[31])
      |=> pend_reg[63] || req_valid_out)
      else $error("bit 31 fall lost");

   // The request stands unchanged until the CPU side takes it.
   hold_task_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (req_valid_out && !req_ack_in)
      |=> req_valid_out && $stable(req_task_out))
      else $error("request dropped before ack");

   // An acknowledged request goes away at once, so it is never served twice.
   ack_drop_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (req_valid_out && req_ack_in)
      |=> !req_valid_out)
      else $error("valid stayed after ack");

   // The history register holds the pattern of the previous clock.
   edge_source_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      ##1 (prev_reg == $past(pattern_in)))
      else $error("history not last pattern");

   // A falling edge on bit 0 lands in slot 1, apart from the rising slot.
   fall_slot_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (irq_enable_in[0] && !pattern_in[0] && prev_reg[0])
      |=> pend_reg[1])
      else $error("bit 0 fall not queued");

   // The last bit's rising edge uses the slot below the last.
   top_rise_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (irq_enable_in[31] && pattern_in[31] && !prev_reg[31])
      |=> pend_reg[62])
      else $error("bit 31 rise not queued");

   // A masked bit never fills either of its two slots.
   mask_bit_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (!irq_enable_in[5])
      |-> (new_edges[11:10] == 2'b00))
      else $error("masked bit made an edge");

   // An unchanged pattern makes no edge, whatever the pins do.
   quiet_pattern_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (pattern_in == prev_reg)
      |-> (new_edges == `OEIM_PEND_RST))
      else $error("edge without pattern change");

   // Rising and falling slots of one bit give task numbers of different parity.
   pair_parity_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (take_w)
      |=> req_task_out[0] == ($past(task_base_in[0]) ^ $past(slot[0])))
      else $error("task parity wrong");

   // A queued edge waits until it is served.
   pend_keep_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (pend_reg[0] && !take_w)
      |=> pend_reg[0])
      else $error("queued edge lost");

   // The slot served is the lowest one pending.
   low_first_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (take_w)
      |-> ((pend_reg & ((64'h0000_0000_0000_0001 << slot) - 64'h0000_0000_0000_0001)) == `OEIM_PEND_RST))
      else $error("lower slot skipped");

   // A served slot leaves the queue unless a fresh edge refills it.
   take_clear_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (take_w && !new_edges[slot])
      |=> !pend_reg[$past(slot)])
      else $error("served slot still pending");

   // Idle means no request on the outputs.
   idle_quiet_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_reg == oeim_pkg::OEIM_IDLE)
      |-> !req_valid_out)
      else $error("request while idle");

   // Busy means the request is shown.
   busy_valid_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_reg == oeim_pkg::OEIM_BUSY)
      |-> req_valid_out)
      else $error("busy without request");

   // Without a pending slot no request is raised.
   no_found_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (state_reg == oeim_pkg::OEIM_IDLE && !found)
      |=> !req_valid_out)
      else $error("request from empty queue");

   // Reset clears the queue, the valid and the overrun outputs; this one runs through reset on purpose.
   rst_clear_a: assert property (@(posedge clk_sys_in)
      $past(sys_rst_in)
      |-> (!req_valid_out && !overrun_out && (pend_reg == `OEIM_PEND_RST)))
      else $error("reset left state behind");

   // No enabled bit means nothing to merge, so no overrun follows.
   quiet_overrun_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (irq_enable_in == 32'h0000_0000)
      |=> !overrun_out)
      else $error("overrun with all bits masked");

   // The last slot maps to base plus sixty-three.
   top_task_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      (take_w && slot == 6'h3f)
      |=> req_task_out == $past(task_base_in) + 8'h3f)
      else $error("last task number wrong");
endmodule : oeim_mapper

// >>> tb/oeim_cpu_model.sv
`timescale 1ns/1ns
// CPU side: accepts a request at once, or when slow once its two-bit wait count, kept across requests, reaches three.
module oeim_cpu_model (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic req_valid_in,
   input wire logic slow_in,
   output logic req_ack_out
);
   logic [1:0] wait_reg;
   // Ack is one cycle long, so a request is never taken twice.
   always_ff @(posedge clk_sys_in) begin
      req_ack_out <= 1'b0;
      if (sys_rst_in) begin
         wait_reg <= 2'h0;
      end else if (req_valid_in && !req_ack_out) begin
         wait_reg <= wait_reg + 2'h1;
         if (!slow_in || wait_reg == 2'h3) req_ack_out <= 1'b1;
      end
   end
endmodule : oeim_cpu_model

// >>> tb/output_edge_interrupt_mapper_tb_top.sv
`timescale 1ns/1ns
`include "oeim_params.svh"
module output_edge_interrupt_mapper_tb_top;
   logic clk_sys_in, sys_rst_in, ack, slow, valid, ovr, seen;
   logic [31:0] pat, en, old;
   logic [7:0] base, tsk;
   int fails = 0, n_tests = 0, q[$];
   oeim_mapper oeim_mapper_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .pattern_in(pat),
      .irq_enable_in(en), .task_base_in(base), .req_ack_in(ack), .req_valid_out(valid), .req_task_out(tsk),
      .overrun_out(ovr));
   oeim_cpu_model oeim_cpu_model_inst (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .req_valid_in(valid), .slow_in(slow), .req_ack_out(ack));
   // Free-running 25 MHz clock.
   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   task stop_test;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   task check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Applies a pattern and expects its enabled edges in slot order, then silence.
   task step(input logic [31:0] p, input logic [31:0] e, input logic [7:0] b);
      int n;
      for (int k = 0; k < 32; k++) if (p[k] != old[k] && e[k]) q.push_back(int'(b) + 2 * k + int'(!p[k]));
      old = p;
      @(posedge clk_sys_in);
      pat <= p;
      en <= e;
      base <= b;
      while (q.size() > 0) begin
         n = 0;
         do begin
            @(negedge clk_sys_in);
            n++;
         end while (!(valid === 1'b1 && ack === 1'b1) && n < 300);
         if (n >= 300) begin
            fails++;
            stop_test();
         end
         check(tsk, 8'(q.pop_front()));
      end
      repeat (8) @(negedge clk_sys_in);
      check({7'h0, valid}, 8'h00);
   endtask : step
   // Main sequence; a slow CPU alternates with a prompt one.
   initial begin
      void'($urandom(32'hb11c));
      sys_rst_in = 1'b1;
      slow = 1'b0;
      pat = 32'h0000_0000;
      en = 32'h0000_0000;
      base = 8'h00;
      old = 32'h0000_0000;
      repeat (16) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      for (int k = 0; k < 32; k++) begin
         slow = k[0];
         step(32'h1 << k, 32'hffff_ffff, 8'($urandom));
         step(32'h0, 32'hffff_ffff, 8'($urandom));
      end
      $display("test single edges done");
      step($urandom, 32'h0, 8'h10);
      step(32'h0, 32'h0, 8'h10);
      $display("test disabled done");
      // Toggle bit 0 each cycle for the first eight of twelve cycles against a slow CPU so a still-pending slot is hit again.
      slow = 1'b1;
      seen = 1'b0;
      @(posedge clk_sys_in);
      en <= 32'h0000_0001;
      base <= 8'h00;
      for (int i = 0; i < 12; i++) begin
         @(posedge clk_sys_in);
         pat <= {31'h0000_0000, (i < 8) && !i[0]};
         @(negedge clk_sys_in);
         if (ovr === 1'b1) seen = 1'b1;
      end
      check({7'h00, seen}, 8'h01);
      // A reset in mid-run drops the queue and the open request.
      @(posedge clk_sys_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      repeat (4) @(negedge clk_sys_in);
      check({7'h00, valid}, 8'h00);
      $display("test overrun done");
      step(32'hffff_ffff, 32'hffff_ffff, 8'hf0);
      for (int i = 0; i < 20; i++) step($urandom, $urandom, 8'($urandom));
      $display("test queued edges done");
      stop_test();
   end
endmodule : output_edge_interrupt_mapper_tb_top
